// >>> hdl/hcths_status.v
`timescale 1ns/1ps
`include "hcths_regs.vh"
// How it works
// - Host writes buffer last byte sets bit 7; CPU read of it clears; interrupts CPU.
// - CPU writes last byte sets bit 6; host read or CPU write 0 clears.
// - Host first-byte write sets bit 5 if CPU ownership clear; CPU last-byte read clears.
// - CPU first-byte write sets bit 4 if host ownership clear; host read or 0 clears.
// - Simultaneous first-byte writes grant the host, CPU ownership stays clear.
// - Bit 2 is CPU read/write, host read only, no hardware effect.
// - Host input data write sets bit 1; CPU read clears; interrupts CPU.
// - CPU output data write sets bit 0; host read or CPU write 0 clears.
// - CPU writing 0 clears writable flags, writing 1 leaves them.
// - Layout holds if buffer enabled or alt select 0; else upper bits general.
module hcths_status (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Host-side cycle events, already in the mclk domain
   input wire host_wr_input_data,
   input wire host_addr_bit2,
   input wire host_rd_output_data,
   input wire host_wr_buffer_first_byte,
   input wire host_wr_buffer_last_byte,
   input wire host_rd_buffer_last_byte,
   // CPU-side accesses
   input wire cpu_rd_input_data,
   input wire cpu_wr_output_data,
   input wire cpu_wr_buffer_first_byte,
   input wire cpu_wr_buffer_last_byte,
   input wire cpu_rd_buffer_last_byte,
   input wire cpu_wr_status,
   input wire [7:0] cpu_wdata,
   // Layout control
   input wire bidir_buffer_enable,
   input wire alt_status_layout_select,
   // Status and interrupt requests
   output reg [7:0] channel3_handshake_status,
   output reg input_full_irq,
   output reg buffer_input_full_irq
);
   wire std_layout;
   wire [3:0] hi_q;
   wire [3:0] hi_set;
   wire [3:0] hi_clr;
   wire cpu_clr_bout;
   wire cpu_clr_cown;
   wire cpu_clr_out;
   reg [3:0] gp_hi;
   reg gp2;
   reg cmd;
   wire in_full;
   wire out_full;

   assign std_layout = bidir_buffer_enable | ~alt_status_layout_select;
   // ==========================================
   // CPU clear-by-zero writes.
   assign cpu_clr_bout = cpu_wr_status & std_layout & ~cpu_wdata[`HCTHS_BIT_BUF_OUT_FULL_S];
   assign cpu_clr_cown = cpu_wr_status & std_layout & ~cpu_wdata[`HCTHS_BIT_CPU_OWN_S];
   assign cpu_clr_out = cpu_wr_status & ~cpu_wdata[`HCTHS_BIT_OUT_FULL];

   // ==========================================
   // Buffer flags.
   assign hi_set[`HCTHS_BIT_BUF_IN_FULL] = host_wr_buffer_last_byte;
   assign hi_clr[`HCTHS_BIT_BUF_IN_FULL] = cpu_rd_buffer_last_byte;
   assign hi_set[`HCTHS_BIT_BUF_OUT_FULL] = cpu_wr_buffer_last_byte;
   assign hi_clr[`HCTHS_BIT_BUF_OUT_FULL] = host_rd_buffer_last_byte | cpu_clr_bout;
   assign hi_set[`HCTHS_BIT_HOST_OWN] = host_wr_buffer_first_byte
      & ~hi_q[`HCTHS_BIT_CPU_OWN];
   assign hi_clr[`HCTHS_BIT_HOST_OWN] = cpu_rd_buffer_last_byte;
   // Host wins a tie because its request masks the CPU's in the same cycle.
   assign hi_set[`HCTHS_BIT_CPU_OWN] = cpu_wr_buffer_first_byte & ~hi_q[`HCTHS_BIT_HOST_OWN]
      & ~hi_set[`HCTHS_BIT_HOST_OWN];
   assign hi_clr[`HCTHS_BIT_CPU_OWN] = host_rd_buffer_last_byte | cpu_clr_cown;

   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_hi
         hcths_flag u_flag (
            .mclk(mclk),
            .rst_n(rst_n),
            .set(hi_set[i]),
            .clr(hi_clr[i]),
            .q(hi_q[i])
         );
      end
   endgenerate

   // ==========================================
   // Single-byte channel flags.
   hcths_flag u_in_full (
      .mclk(mclk),
      .rst_n(rst_n),
      .set(host_wr_input_data),
      .clr(cpu_rd_input_data),
      .q(in_full)
   );
   hcths_flag u_out_full (
      .mclk(mclk),
      .rst_n(rst_n),
      .set(cpu_wr_output_data),
      .clr(host_rd_output_data | cpu_clr_out),
      .q(out_full)
   );

   // ==========================================
   // Plain bits: command flag and general-purpose bits.
   always @(posedge mclk) begin
      if (!rst_n) begin
         cmd <= 1'b0;
         gp2 <= 1'b0;
         gp_hi <= 4'h0;
      end else begin
         if (host_wr_input_data) begin
            cmd <= host_addr_bit2;
         end
         if (cpu_wr_status) begin
            gp2 <= cpu_wdata[`HCTHS_BIT_GP2];
            if (!std_layout) begin
               gp_hi <= cpu_wdata[7:4];
            end
         end
      end
   end

   // ==========================================
   // Registered outputs, one cycle behind the flags. Host writes have no path here.
   always @(posedge mclk) begin
      if (!rst_n) begin
         channel3_handshake_status <= `HCTHS_STATUS_RESET;
         input_full_irq <= 1'b0;
         buffer_input_full_irq <= 1'b0;
      end else begin
         channel3_handshake_status <= {(std_layout ? hi_q : gp_hi), cmd, gp2,
            in_full, out_full};
         input_full_irq <= in_full;
         buffer_input_full_irq <= std_layout & hi_q[`HCTHS_BIT_BUF_IN_FULL];
      end
   end
endmodule

// >>> hdl/hcths_regs.vh
`ifndef HCTHS_REGS_VH
`define HCTHS_REGS_VH
// ==========================================
// Status register bit positions.
`define HCTHS_BIT_BUF_IN_FULL 3
`define HCTHS_BIT_BUF_OUT_FULL 2
`define HCTHS_BIT_HOST_OWN 1
`define HCTHS_BIT_CPU_OWN 0
`define HCTHS_BIT_BUF_IN_FULL_S 7
`define HCTHS_BIT_BUF_OUT_FULL_S 6
`define HCTHS_BIT_HOST_OWN_S 5
`define HCTHS_BIT_CPU_OWN_S 4
`define HCTHS_BIT_CMD 3
`define HCTHS_BIT_GP2 2
`define HCTHS_BIT_IN_FULL 1
`define HCTHS_BIT_OUT_FULL 0
// ==========================================
// Reset value.
`define HCTHS_STATUS_RESET 8'h00
`endif

// >>> hdl/hcths_flag.v
`timescale 1ns/1ps
// ==========================================
// One sticky flag; a set in the same cycle as a clear wins.
module hcths_flag (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Control
   input wire set,
   input wire clr,
   output reg q
);
   always @(posedge mclk) begin
      if (!rst_n) begin
         q <= 1'b0;
      end else if (set) begin
         q <= 1'b1;
      end else if (clr) begin
         q <= 1'b0;
      end
   end
endmodule

// >>> tb/hcths_props.sv
`timescale 1ns/1ps
// ==========================================
// Status flag checks.
module hcths_props (
input wire logic mclk, rst_n, host_wr_input_data, host_addr_bit2, host_rd_output_data,
input wire logic host_wr_buffer_first_byte, cpu_wr_buffer_first_byte, cpu_wr_output_data,
input wire logic cpu_rd_input_data, cpu_wr_status, input_full_irq, bidir_buffer_enable,
input wire logic [7:0] cpu_wdata, channel3_handshake_status
);
wire [7:0] s = channel3_handshake_status;
default clocking @(posedge mclk); endclocking
default disable iff (!rst_n);
a_in_set: assert property (host_wr_input_data |-> ##2 s[1]) else $error("in set");
a_in_clear: assert property (cpu_rd_input_data && !host_wr_input_data |-> ##2 !s[1])
   else $error("in clear");
a_cmd_copy: assert property (host_wr_input_data |-> ##2 s[3] == $past(host_addr_bit2, 2))
   else $error("cmd bit");
a_irq_level: assert property (input_full_irq == s[1]) else $error("irq");
a_out_set: assert property (cpu_wr_output_data |-> ##2 s[0]) else $error("out set");
a_out_clear: assert property (host_rd_output_data && !cpu_wr_output_data |-> ##2 !s[0])
   else $error("out clear");
a_host_wins: assert property (host_wr_buffer_first_byte && cpu_wr_buffer_first_byte
   && !s[4] && bidir_buffer_enable |-> ##2 s[5] && !s[4]) else $error("grant");
a_one_keeps: assert property (cpu_wr_status && cpu_wdata[0] && s[0]
   && !host_rd_output_data |-> ##2 s[0]) else $error("keep");
a_reset_zero: assert property (disable iff (1'b0) !rst_n |=> s == 8'h00)
   else $error("reset");
cover property (host_wr_input_data && host_addr_bit2);
cover property (host_wr_buffer_first_byte && cpu_wr_buffer_first_byte);
cover property (cpu_wr_status && !cpu_wdata[0] && s[0]);
endmodule
bind hcths_status hcths_props u_props (.*);

// >>> tb/hcths_host.sv
`timescale 1ns/1ps
// ==========================================
// Host: each request bit passes straight through, unshaped, as its I/O cycle pulse.
module hcths_host (
   // Requests
   input wire [4:0] req,
   // Cycle pulses
   output wire [4:0] pulse
);
assign pulse = req;
endmodule

// >>> tb/tb_host_channel3_handshake_status.sv
`timescale 1ns/1ps
// ==========================================
// Bench: one event, or one same-cycle pair, every three cycles so each result is seen alone.
module tb_host_channel3_handshake_status;
reg mclk = 0, rst_n = 0, a2 = 0, sel = 0, en = 1, rnd = 0, st = 1;
reg [3:0] g = 0;
reg [10:0] e = 0;
reg [7:0] w = 0, x = 0;
wire [7:0] s;
wire i1, i7;
wire [4:0] hp;
integer n_errors = 0, checks_done = 0, cyc = 0, seed = 32'h3244b62f, k;
always #5 mclk = ~mclk;
hcths_host HOST (.req(e[4:0]), .pulse(hp));
hcths_status DUT (.mclk(mclk), .rst_n(rst_n), .host_wr_input_data(hp[0]),
.host_addr_bit2(a2), .host_rd_output_data(hp[1]), .host_wr_buffer_first_byte(hp[2]),
.host_wr_buffer_last_byte(hp[3]), .host_rd_buffer_last_byte(hp[4]),
.cpu_rd_input_data(e[5]), .cpu_wr_output_data(e[6]), .cpu_wr_buffer_first_byte(e[7]),
.cpu_wr_buffer_last_byte(e[8]), .cpu_rd_buffer_last_byte(e[9]), .cpu_wr_status(e[10]),
.cpu_wdata(w), .bidir_buffer_enable(en), .alt_status_layout_select(sel),
.channel3_handshake_status(s), .input_full_irq(i1), .buffer_input_full_irq(i7));
// Clears go first so that a set in the same cycle wins. The buffer flags keep
// running while the alternate layout hides them, so the model tracks them always.
function [7:0] f(input [7:0] o, input [10:0] v, input std);
begin
   f = o;
   if (v[10]) begin
      f[2] = w[2];
      f[0] = o[0] & w[0];
      if (std) begin
         f[6] = o[6] & w[6];
         f[4] = o[4] & w[4];
      end
   end
   if (v[5]) f[1] = 0;
   if (v[1]) f[0] = 0;
   if (v[9]) f[7] = 0;
   if (v[9]) f[5] = 0;
   if (v[4]) f[6] = 0;
   if (v[4]) f[4] = 0;
   if (v[0]) f[1] = 1;
   if (v[0]) f[3] = a2;
   if (v[6]) f[0] = 1;
   if (v[3]) f[7] = 1;
   if (v[8]) f[6] = 1;
   if (v[2] && !o[4]) f[5] = 1;
   else if (v[7] && !o[5]) f[4] = 1;
end
endfunction
task chk(input [9:0] got, input [9:0] want);
begin
   checks_done = checks_done + 1;
   if (got !== want) begin
      n_errors = n_errors + 1;
      $display("wrong value flags expected %h seen %h", want, got);
   end
end
endtask
task step(input [10:0] v);
begin
   @(negedge mclk);
   w = $random(seed);
   a2 = $random(seed);
   sel = $random(seed);
   en = $random(seed) | !rnd;
   st = en | !sel;
   e = v;
   x = f(x, v, st);
   if (v[10] && !st) g = w[7:4];
   @(negedge mclk);
   e = 0;
   @(negedge mclk);
   chk({i7, i1, s}, {st & x[7], x[1], st ? x : {g, x[3:0]}});
end
endtask
task complete_run;
begin
   $display("errors %0d checks %0d", n_errors, checks_done);
   if (n_errors == 0 && checks_done > 0) $display("bench passed");
   else $display("bench failed");
   $finish;
end
endtask
always @(posedge mclk) begin
   cyc <= cyc + 1;
   if (cyc == 2000) begin
      n_errors = n_errors + 1;
      complete_run;
   end
end
initial begin
   repeat (8) @(negedge mclk);
   rst_n = 1;
   chk({i7, i1, s}, 10'h000);
   step(11'h084);
   step(11'h200);
   step(11'h080);
   step(11'h004);
   step(11'h010);
   step(11'h021);
   step(11'h042);
   rnd = 1;
   for (k = 0; k < 300; k = k + 1) step(11'h001 << ({$random(seed)} % 11));
   // A reset in mid-run must wipe every flag and the general-purpose bits.
   @(negedge mclk);
   rst_n = 0;
   repeat (2) @(negedge mclk);
   rst_n = 1;
   x = 0;
   g = 0;
   chk({i7, i1, s}, 10'h000);
   step(11'h001);
   complete_run;
end
endmodule
